/* include/lrc_pkg.sv */
// Package of constants and types shared by both ends of the laser real-time link.
// Function
// - Controller asserts run permit after supply present.
// - Fault clears only by permit off-then-on toggle.
// - Fault output high while system fault present.
// - Output follows on-command high, stops when low.
// - Duty warning marks only the inhibited pulse portion.
// - Reflection warning only while protection inhibits command.
// - Both warnings low whenever on-command low.
// - Over-long pulse truncated at maximum, warning raised.
// - Duty is width over period, kept within maximum.
// - Controller inhibits commands while supply absent.
// - Run permit is not a safety interlock.
// - Temperature or shutter fault latches and shuts down.
// - Fault output follows shutdown within cycles.
package lrc_pkg;

    // ----------------------------------------------------------------
    // Timing and widths
    // ----------------------------------------------------------------
    localparam int CNT_W          = 24;
    localparam int CLK_MHZ        = 125;
    localparam int MAX_WIDTH_US   = 1000;
    localparam int MAX_WIDTH_CYC  = MAX_WIDTH_US * CLK_MHZ;
    localparam int MAX_DUTY_PCT   = 60;
    localparam int DUTY_SCALE     = 100;

    // ----------------------------------------------------------------
    // APB register map of the controller
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_WIDTH   = 8'h04;
    localparam logic [7:0] REG_PERIOD  = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    localparam logic [7:0] REG_IRQ_ST  = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR = 8'h14;
    localparam logic [7:0] REG_IRQ_EN  = 8'h18;

    // Control bit positions.
    localparam int CTRL_PERMIT = 0;
    localparam int CTRL_RUN    = 1;
    localparam int CTRL_CLEAR  = 2;

    // Status and interrupt bit positions.
    localparam int ST_FAULT    = 0;
    localparam int ST_DUTY     = 1;
    localparam int ST_REFL     = 2;
    localparam int ST_SUPPLY   = 3;
    localparam int IRQ_W       = 3;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        LRC_IDLE,
        LRC_OPEN,
        LRC_CLOSE
    } lrc_clear_e;

endpackage

/* include/lrc_link_if.sv */
// Interface joining the laser control logic and the external controller.
`timescale 1ns/1ps
`default_nettype none
interface lrc_link_if;
    logic run_permit;
    logic on_cmd;
    logic system_fault;
    logic duty_warning;
    logic reflection_warning;

    modport device (
        input  run_permit,
        input  on_cmd,
        output system_fault,
        output duty_warning,
        output reflection_warning
    );

    modport controller (
        output run_permit,
        output on_cmd,
        input  system_fault,
        input  duty_warning,
        input  reflection_warning
    );
endinterface
`default_nettype wire

/* core/lrc_device.sv */
// Laser real-time control logic: gating, pulse clip, duty and fault flags.
`timescale 1ns/1ps
`default_nettype none
module lrc_device
    import lrc_pkg::*;
#(
    parameter int MAX_WIDTH = MAX_WIDTH_CYC,
    parameter int MAX_DUTY  = MAX_DUTY_PCT
) (
    // Clock and reset
    input  wire logic   CORE_CLK,
    input  wire logic   RST,
    input  wire logic   CE,
    // Link
    lrc_link_if.device  LINK,
    // Plant
    input  wire logic   TEMP_FAULT,
    input  wire logic   SHUTTER_FAULT,
    input  wire logic   REFL_OVER,
    output logic        LASER_ON
);

    if (MAX_WIDTH < 1 || MAX_WIDTH >= (1 << CNT_W)
        || MAX_DUTY < 1 || MAX_DUTY > DUTY_SCALE) begin : g_bad_param
        $error("lrc_device: bad parameters");
    end

    // ----------------------------------------------------------------
    // Fault latch and clear toggle
    // ----------------------------------------------------------------
    logic             fault;
    logic             permit_seen_low;
    logic [CNT_W-1:0] width_cnt;
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] last_period;
    logic [CNT_W-1:0] cur_width;
    logic [CNT_W-1:0] ref_period;
    logic             pulse_start;
    logic             cmd_d;
    logic             duty_bad;
    logic             width_bad;
    logic             gate;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            fault           <= 1'b0;
            permit_seen_low <= 1'b0;
        end else if (CE) begin
            if (TEMP_FAULT || SHUTTER_FAULT) begin
                fault           <= 1'b1;
                permit_seen_low <= 1'b0;
            end else if (fault && !LINK.run_permit) begin
                permit_seen_low <= 1'b1;
            end else if (fault && permit_seen_low && LINK.run_permit) begin
                fault           <= 1'b0;
                permit_seen_low <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pulse width and period measurement
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cmd_d       <= 1'b0;
            width_cnt   <= '0;
            period_cnt  <= '1;
            last_period <= '1;
        end else if (CE) begin
            cmd_d <= LINK.on_cmd;
            if (pulse_start) begin
                width_cnt   <= CNT_W'(1);
                period_cnt  <= CNT_W'(1);
                last_period <= period_cnt;
            end else begin
                if (LINK.on_cmd && width_cnt != '1) begin
                    width_cnt <= width_cnt + CNT_W'(1);
                end
                if (period_cnt != '1) begin
                    period_cnt <= period_cnt + CNT_W'(1);
                end
            end
        end
    end

    // A new pulse starts from zero width and is held against the last closed period.
    assign pulse_start = LINK.on_cmd && !cmd_d;
    assign cur_width   = pulse_start ? '0 : width_cnt;
    assign ref_period  = pulse_start ? period_cnt : last_period;
    assign width_bad   = cur_width >= CNT_W'(MAX_WIDTH);
    assign duty_bad    = ((48'(cur_width) + 48'h1) * 48'(DUTY_SCALE))
                         > (48'(ref_period) * 48'(MAX_DUTY));
    assign gate      = LINK.on_cmd && LINK.run_permit && !fault;

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            LASER_ON                <= 1'b0;
            LINK.duty_warning       <= 1'b0;
            LINK.reflection_warning <= 1'b0;
            LINK.system_fault       <= 1'b0;
        end else if (CE) begin
            LASER_ON                <= gate && !width_bad && !duty_bad && !REFL_OVER
                                       && !TEMP_FAULT && !SHUTTER_FAULT;
            LINK.duty_warning       <= gate && (width_bad || duty_bad);
            LINK.reflection_warning <= gate && REFL_OVER;
            LINK.system_fault       <= fault || TEMP_FAULT || SHUTTER_FAULT;
        end
    end

endmodule
`default_nettype wire

/* core/lrc_controller.sv */
// External controller end: APB registers driving run permit and pulse train.
`timescale 1ns/1ps
`default_nettype none
module lrc_controller
    import lrc_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    // Supply monitor
    input  wire logic        SUPPLY_OK,
    // Link
    lrc_link_if.controller   LINK
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [2:0]       ctrl;
    logic [CNT_W-1:0] width;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] phase;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] ev;
    logic             fault_d;
    logic             duty_d;
    logic             refl_d;
    lrc_clear_e       clr_state;
    logic             wr;
    logic             rd;

    assign wr = CE && PSEL && PENABLE && PWRITE;
    assign rd = CE && PSEL && !PENABLE && !PWRITE;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl   <= '0;
            width  <= '0;
            period <= '0;
            irq_en <= '0;
        end else if (wr) begin
            unique case (PADDR)
                REG_CTRL:   ctrl   <= PWDATA[2:0];
                REG_WIDTH:  width  <= PWDATA[CNT_W-1:0];
                REG_PERIOD: period <= PWDATA[CNT_W-1:0];
                REG_IRQ_EN: irq_en <= PWDATA[IRQ_W-1:0];
                default:    ;
            endcase
        end else if (CE && clr_state == LRC_CLOSE) begin
            ctrl[CTRL_CLEAR] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // APB answer: one setup, one access cycle, zero wait states
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRDATA  <= RESET_WORD;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && PADDR > REG_IRQ_EN;
            if (rd) begin
                unique case (PADDR)
                    REG_CTRL:   PRDATA <= {29'h0, ctrl};
                    REG_WIDTH:  PRDATA <= {8'h00, width};
                    REG_PERIOD: PRDATA <= {8'h00, period};
                    REG_STATUS: PRDATA <= {28'h0, SUPPLY_OK, LINK.reflection_warning,
                                           LINK.duty_warning, LINK.system_fault};
                    REG_IRQ_ST: PRDATA <= {29'h0, irq_st};
                    REG_IRQ_EN: PRDATA <= {29'h0, irq_en};
                    default:    PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: rising edges of the three status inputs, set wins
    // ----------------------------------------------------------------
    assign ev = {LINK.reflection_warning & ~refl_d, LINK.duty_warning & ~duty_d,
                 LINK.system_fault & ~fault_d};

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            irq_st  <= '0;
            fault_d <= 1'b0;
            duty_d  <= 1'b0;
            refl_d  <= 1'b0;
            IRQ     <= 1'b0;
        end else if (CE) begin
            fault_d <= LINK.system_fault;
            duty_d  <= LINK.duty_warning;
            refl_d  <= LINK.reflection_warning;
            if (wr && PADDR == REG_IRQ_CLR) begin
                irq_st <= (irq_st & ~PWDATA[IRQ_W-1:0]) | ev;
            end else begin
                irq_st <= irq_st | ev;
            end
            IRQ <= |(irq_st & irq_en);
        end
    end

    // ----------------------------------------------------------------
    // Fault clear: open the permit for one cycle, then close again
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            clr_state <= LRC_IDLE;
        end else if (CE) begin
            unique case (clr_state)
                LRC_IDLE:  if (ctrl[CTRL_CLEAR]) clr_state <= LRC_OPEN;
                LRC_OPEN:  clr_state <= LRC_CLOSE;
                LRC_CLOSE: clr_state <= LRC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pulse generator and link drive
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            phase           <= '0;
            LINK.on_cmd     <= 1'b0;
            LINK.run_permit <= 1'b0;
        end else if (CE) begin
            if (phase + CNT_W'(1) >= period) begin
                phase <= '0;
            end else begin
                phase <= phase + CNT_W'(1);
            end
            LINK.on_cmd     <= SUPPLY_OK && ctrl[CTRL_RUN] && phase < width;
            LINK.run_permit <= SUPPLY_OK && ctrl[CTRL_PERMIT]
                               && clr_state != LRC_OPEN;
        end
    end

endmodule
`default_nettype wire

/* tb/lrc_monitor.sv */
// Checker of the laser link: gating, pulse clip, warnings and fault latch.
`timescale 1ns/1ps
`default_nettype none
module lrc_monitor
    import lrc_pkg::*;
#(
    parameter int MAX_WIDTH = MAX_WIDTH_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic run_permit,
    input wire logic on_cmd,
    input wire logic system_fault,
    input wire logic duty_warning,
    input wire logic reflection_warning,
    input wire logic LASER_ON,
    input wire logic TEMP_FAULT,
    input wire logic SHUTTER_FAULT,
    input wire logic REFL_OVER
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] on_cnt;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Counts the cycles of the current output pulse.
    always_ff @(posedge CORE_CLK) begin
        if (RST || !LASER_ON) begin
            on_cnt <= '0;
        end else begin
            on_cnt <= on_cnt + 1'b1;
        end
    end
    a_warn_idle_low: assert property (!on_cmd |=> !duty_warning && !reflection_warning)
        else $error("warning high without on-command");
    a_out_needs_cmd: assert property (!on_cmd |=> !LASER_ON)
        else $error("output without on-command");
    a_out_follows: assert property ($rose(on_cmd) && run_permit && $past(run_permit)
        && !system_fault && !TEMP_FAULT && !SHUTTER_FAULT && !REFL_OVER |=> LASER_ON)
        else $error("output did not follow on-command");
    a_permit_dark: assert property (!run_permit |=> !LASER_ON)
        else $error("output without run permit");
    a_fault_dark: assert property (system_fault |-> !LASER_ON)
        else $error("output while fault present");
    a_fault_latch: assert property (TEMP_FAULT || SHUTTER_FAULT |=> system_fault)
        else $error("fault not reported");
    a_fault_holds: assert property (system_fault && run_permit && $past(run_permit)
        && $past(run_permit, 2) |=> system_fault)
        else $error("fault cleared without permit toggle");
    a_clip_width: assert property (on_cnt <= CNT_W'(MAX_WIDTH))
        else $error("pulse longer than maximum width");
    a_clip_warn: assert property (on_cnt == CNT_W'(MAX_WIDTH) && on_cmd |-> ##[0:1] duty_warning)
        else $error("clip without duty warning");
    a_duty_dark: assert property (duty_warning |-> !LASER_ON)
        else $error("duty warning on uninhibited output");
    a_refl_inhibit: assert property (on_cmd && REFL_OVER && run_permit && !system_fault
        |=> reflection_warning && !LASER_ON)
        else $error("reflection not inhibited");
    a_refl_cause: assert property (reflection_warning |-> $past(REFL_OVER) && $past(on_cmd))
        else $error("reflection warning without cause");
    c_fault: cover property ($rose(system_fault));
    c_duty: cover property ($rose(duty_warning));
    c_refl: cover property ($rose(reflection_warning));
    c_clip: cover property ($fell(LASER_ON) && on_cmd);
endmodule
`default_nettype wire

/* tb/tb.sv */
// Testbench joining controller and device over the link, driven over APB.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lrc_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam int MAX_W = 20;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic        supply_ok, temp_f, shut_f, refl_over, laser_on;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          mismatches, total_checks, n_las, n_duty, n_refl, n_cmd, n_flt;
    logic [7:0]  ra [6] = '{REG_CTRL, REG_WIDTH, REG_PERIOD, REG_STATUS, REG_IRQ_ST, REG_IRQ_EN};
    lrc_link_if link ();
    lrc_device #(.MAX_WIDTH(MAX_W)) u_lrc_device (.CORE_CLK(clk), .RST(rst), .CE(1'b1),
        .LINK(link), .TEMP_FAULT(temp_f), .SHUTTER_FAULT(shut_f), .REFL_OVER(refl_over),
        .LASER_ON(laser_on));
    lrc_controller u_lrc_controller (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .SUPPLY_OK(supply_ok), .LINK(link));
    lrc_monitor #(.MAX_WIDTH(MAX_W)) u_lrc_monitor (.CORE_CLK(clk), .RST(rst),
        .run_permit(link.run_permit), .on_cmd(link.on_cmd), .system_fault(link.system_fault),
        .duty_warning(link.duty_warning), .reflection_warning(link.reflection_warning),
        .LASER_ON(laser_on), .TEMP_FAULT(temp_f), .SHUTTER_FAULT(shut_f), .REFL_OVER(refl_over));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            final_report();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(q, exp);
    endtask
    // Counts high cycles of the watched levels over n edges.
    task watch(input int n);
        n_las = 0;
        n_duty = 0;
        n_refl = 0;
        n_cmd = 0;
        n_flt = 0;
        repeat (n) begin
            @(posedge clk);
            n_las += int'(laser_on === 1'b1);
            n_duty += int'(link.duty_warning === 1'b1);
            n_refl += int'(link.reflection_warning === 1'b1);
            n_cmd += int'(link.on_cmd === 1'b1);
            n_flt += int'(link.system_fault === 1'b1);
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 43'h0};
        {supply_ok, temp_f, shut_f, refl_over} <= 4'h0;
        mismatches = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ra[k]) rd(ra[k], RESET_WORD);
        chk(irq, 1'b0);
        apb(1'b0, 8'h1C, '0);
        chk(e, 1'b1);
        wr(REG_STATUS, 32'hFFFF_FFFF);
        rd(REG_STATUS, RESET_WORD);
        wr(REG_WIDTH, 32'h5);
        wr(REG_PERIOD, 32'h14);
        wr(REG_CTRL, 32'h3);
        watch(100);
        chk(n_cmd, 0);
        chk(link.run_permit, 1'b0);
        supply_ok <= 1'b1;
        watch(60);
        chk(link.run_permit, 1'b1);
        rd(REG_STATUS, 32'h1 << ST_SUPPLY);
        watch(200);
        chk(n_cmd, 50);
        chk(n_las, 50);
        chk(n_duty, 0);
        chk(n_flt, 0);
        wr(REG_WIDTH, 32'h1E);
        wr(REG_PERIOD, 32'h64);
        watch(150);
        watch(200);
        chk(n_las, 2 * MAX_W);
        chk(n_duty, 2 * (30 - MAX_W));
        wr(REG_IRQ_EN, 32'h2);
        rd(REG_IRQ_ST, 32'h2);
        chk(irq, 1'b1);
        wr(REG_IRQ_EN, 32'h0);
        rd(REG_IRQ_ST, 32'h2);
        chk(irq, 1'b0);
        wr(REG_CTRL, 32'h1);
        watch(120);
        wr(REG_IRQ_CLR, 32'h2);
        wr(REG_IRQ_EN, 32'h2);
        rd(REG_IRQ_ST, 32'h0);
        chk(irq, 1'b0);
        wr(REG_WIDTH, 32'hF);
        wr(REG_PERIOD, 32'h14);
        wr(REG_CTRL, 32'h3);
        watch(200);
        chk(n_duty != 0, 1'b1);
        chk(n_las < 150, 1'b1);
        watch(200);
        chk(n_las, 10 * (20 * MAX_DUTY_PCT / DUTY_SCALE));
        chk(n_duty, 10 * (15 - 20 * MAX_DUTY_PCT / DUTY_SCALE));
        chk(irq, 1'b1);
        wr(REG_WIDTH, 32'h5);
        watch(100);
        refl_over <= 1'b1;
        watch(4);
        watch(200);
        chk(n_las, 0);
        chk(n_refl, 50);
        refl_over <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            temp_f <= (k == 0);
            shut_f <= (k == 1);
            @(posedge clk);
            temp_f <= 1'b0;
            shut_f <= 1'b0;
            watch(100);
            chk(n_flt, 100);
            chk(n_las, 0);
            rd(REG_STATUS, (32'h1 << ST_SUPPLY) | (32'h1 << ST_FAULT));
            wr(REG_CTRL, 32'h7);
            watch(20);
            chk(link.system_fault, 1'b0);
            rd(REG_CTRL, (32'h1 << CTRL_PERMIT) | (32'h1 << CTRL_RUN));
            watch(200);
            chk(n_las, 50);
        end
        final_report();
    end
endmodule
`default_nettype wire
